// ### usr_pkg.sv
// Constants and types shared by the user special register block
package usr_pkg;

  // ==========================================================
  // Special-register numbers
  // ==========================================================
  localparam logic [9:0] SPR_FLAGS       = 10'h001; // Exception flags
  localparam logic [9:0] SPR_LINK        = 10'h008; // Link return address
  localparam logic [9:0] SPR_COUNT       = 10'h009; // Loop count
  localparam logic [9:0] SPR_TB_RD_LOWER = 10'h10C; // Time base low, read
  localparam logic [9:0] SPR_TB_RD_UPPER = 10'h10D; // Time base high, read
  localparam logic [9:0] SPR_TB_WR_LOWER = 10'h11C; // Time base low, write
  localparam logic [9:0] SPR_TB_WR_UPPER = 10'h11D; // Time base high, write

  // ==========================================================
  // Flag register field positions (bit 31 of the map is the MSB)
  // ==========================================================
  localparam int XF_SUMMARY  = 31; // Sticky summary overflow
  localparam int XF_OVERFLOW = 30; // Overflow
  localparam int XF_CARRY    = 29; // Carry
  localparam int XF_KEEP_HI  = 15; // Software scratch field, top
  localparam int XF_KEEP_LO  = 8;  // Software scratch field, bottom
  localparam int XF_BYTES_HI = 6;  // String byte count, top
  localparam int XF_BYTES_LO = 0;  // String byte count, bottom

  // ==========================================================
  // Masks and reset values
  // ==========================================================
  localparam logic [31:0] FLAGS_WRITE_MASK = 32'hE000FF7F; // Stored bits
  localparam logic [31:0] FLAGS_RESET      = 32'h00000000; // After reset
  localparam logic [31:0] TARGET_MASK      = 32'hFFFFFFFC; // Word align
  localparam logic [31:0] RDATA_RESET      = 32'h00000000; // Read bus idle
  localparam logic [5:0]  SHIFT_LIMIT      = 6'h20;        // Full shift

  // ==========================================================
  // Operation classes from the execution unit
  // ==========================================================
  typedef enum logic [2:0] {
    OP_OTHER,       // Cannot carry or overflow
    OP_COMPARE,     // Compare, flags untouched
    OP_ADD,         // Plain add, overflow only
    OP_SUBF,        // Plain subtract-from, overflow only
    OP_ADD_CARRY,   // Add carrying or extended
    OP_SUBF_CARRY,  // Subtract-from carrying or extended
    OP_SHIFT_ALG    // Shift right algebraic
  } usr_op_t;

endpackage : usr_pkg

// ### usr_flag_if.sv
// Operand and flag signals between the register block and its calculator
`timescale 1ns/1ps
interface usr_flag_if;
  usr_pkg::usr_op_t opKind;          // Operation class
  logic             extended;        // Use stored carry as carry in
  logic             carryFlag;       // Stored carry flag
  logic [31:0]      opA;             // First operand
  logic [31:0]      opB;             // Second operand
  logic [5:0]       shiftAmt;        // Shift amount
  logic [31:0]      result;          // Whole instruction result
  logic             carryOut;        // New carry value
  logic             carryUpdate;     // Carry is to be written
  logic             overflowOut;     // New overflow value

  // Calculator side
  modport calc  (input opKind, extended, carryFlag, opA, opB, shiftAmt,
                 output result, carryOut, carryUpdate, overflowOut);
  // Register owner side
  modport owner (output opKind, extended, carryFlag, opA, opB, shiftAmt,
                 input result, carryOut, carryUpdate, overflowOut);
endinterface : usr_flag_if

// ### usr_flag_calc.sv
// Result, carry and overflow of one whole integer operation
`timescale 1ns/1ps
module usr_flag_calc (
  // Operands in, flags out
  usr_flag_if.calc flags
);

  // Three-way sum with carry out of the top bit
  function automatic logic [32:0] sum3(input logic [31:0] a,
                                       input logic [31:0] b,
                                       input logic        cin);
    sum3 = {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
  endfunction

  logic [32:0] addSum;     // Sum of the whole instruction
  logic        carryIn;    // Carry into the low bit
  logic [31:0] firstOp;    // First operand, inverted for subtract
  logic        isSub;      // Subtract-from operation
  logic [31:0] shifted;    // Algebraic shift result
  logic [31:0] lostMask;   // Bits shifted out
  logic        isCarryOp;  // Carrying add or subtract

  // Operand preparation
  always_comb begin
    isSub     = (flags.opKind == usr_pkg::OP_SUBF) ||
                (flags.opKind == usr_pkg::OP_SUBF_CARRY);
    isCarryOp = (flags.opKind == usr_pkg::OP_ADD_CARRY) ||
                (flags.opKind == usr_pkg::OP_SUBF_CARRY);
    firstOp   = isSub ? ~flags.opA : flags.opA;
    // Extended forms take the stored carry, subtract otherwise adds one
    carryIn   = flags.extended ? flags.carryFlag : isSub;
    addSum    = sum3(firstOp, flags.opB, carryIn);
  end

  // Algebraic right shift and the bits it discards
  always_comb begin
    if (flags.shiftAmt >= usr_pkg::SHIFT_LIMIT) begin
      shifted  = {32{flags.opA[31]}};
      lostMask = 32'hFFFFFFFF;
    end else begin
      shifted  = 32'($signed(flags.opA) >>> flags.shiftAmt);
      lostMask = ~(32'hFFFFFFFF << flags.shiftAmt);
    end
  end

  // Result and flag selection
  always_comb begin
    flags.result      = addSum[31:0];
    flags.carryOut    = 1'b0;
    flags.carryUpdate = 1'b0;
    // carry into sign differs from out
    flags.overflowOut = (firstOp[31] == flags.opB[31]) &&
                        (addSum[31] != firstOp[31]);
    if (flags.opKind == usr_pkg::OP_SHIFT_ALG) begin
      flags.result      = shifted;
      flags.carryOut    = flags.opA[31] && ((flags.opA & lostMask) != 0);
      flags.carryUpdate = 1'b1;
    end else if (isCarryOp) begin
      flags.carryOut    = addSum[32];
      flags.carryUpdate = 1'b1;
    end
  end

endmodule // usr_flag_calc

// ### usr_special_regs.sv
// User-level special registers: flags, link, loop count and time base
//
// Function
// - Flags register, 32 bits, number 1
// - Flags come from the whole result
// - Summary overflow sticks until software clears
// - Overflow when top two carries differ
// - Carrying adds set carry from top
// - Algebraic shift carry: negative, ones lost
// - Compares leave carry and overflow alone
// - Scratch byte kept, other reserved zero
// - Low seven bits hold string count
// - Link register feeds branch, number 8
// - Link stores low bits, target drops
// - Branch with link saves next address
// - Loop count decrements and wraps, number 9
// - Loop count feeds count branch target
// - Time base is 64-bit up counter
// - Time base seen as two halves
// - User reads time base, supervisor writes
// - Time base read at 268 and 269
// - Full time base takes two reads
`timescale 1ns/1ps
module usr_special_regs (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Special-register access port
  input  wire logic [9:0]       sprNum,
  input  wire logic             sprRead,
  input  wire logic             sprWrite,
  input  wire logic [31:0]      sprWdata,
  input  wire logic             supervisor,
  output logic      [31:0]      sprRdata,
  output logic                  sprRdValid,
  output logic                  sprRefused,
  // Integer operation port
  input  wire logic             opValid,
  input  wire usr_pkg::usr_op_t opKind,
  input  wire logic             opExtended,
  input  wire logic             opOverflowEnable,
  input  wire logic [31:0]      opA,
  input  wire logic [31:0]      opB,
  input  wire logic [5:0]       opShift,
  output logic      [31:0]      opResult,
  output logic                  opDone,
  // Branch unit port
  input  wire logic             brValid,
  input  wire logic             brLink,
  input  wire logic             brDecCount,
  input  wire logic [31:0]      brNextAddr,
  output logic      [31:0]      linkTarget,
  output logic      [31:0]      countTarget,
  output logic      [31:0]      loopCountNow,
  // Time base
  input  wire logic             tbTick,
  // Flag register fields
  output logic                  summaryOverflow,
  output logic                  overflowFlag,
  output logic                  carryFlag,
  output logic      [6:0]       stringBytes
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [31:0] flagsReg;        // Exception flags register
  logic [31:0] linkAddr;        // Link return address
  logic [31:0] loopCount;       // Loop count
  logic [63:0] timeBase;        // Time base counter
  logic [31:0] next_flags;      // Flags after this cycle
  logic [31:0] next_rdata;      // Read data for this access
  logic        next_refused;    // Access refused this cycle

  // ==========================================================
  // Decoding
  // ==========================================================
  logic        wrFlags;         // Write to flags register
  logic        wrLink;          // Write to link register
  logic        wrCount;         // Write to loop count
  logic        wrTbLower;       // Supervisor write, time base low
  logic        wrTbUpper;       // Supervisor write, time base high
  logic        opFlagUpdate;    // Operation may touch flags
  logic        ovUpdate;        // Overflow is written this cycle
  logic        ovSet;           // Overflow is set this cycle

  // Match a number against one register
  function automatic logic sprHit(input logic [9:0] num,
                                  input logic [9:0] target);
    sprHit = (num == target);
  endfunction

  // Drop the two low address bits of a branch target
  function automatic logic [31:0] alignTarget(input logic [31:0] addr);
    alignTarget = addr & usr_pkg::TARGET_MASK;
  endfunction

  // Write strobes
  always_comb begin
    wrFlags   = sprWrite && sprHit(sprNum, usr_pkg::SPR_FLAGS);
    wrLink    = sprWrite && sprHit(sprNum, usr_pkg::SPR_LINK);
    wrCount   = sprWrite && sprHit(sprNum, usr_pkg::SPR_COUNT);
    wrTbLower = sprWrite && supervisor &&
                sprHit(sprNum, usr_pkg::SPR_TB_WR_LOWER);
    wrTbUpper = sprWrite && supervisor &&
                sprHit(sprNum, usr_pkg::SPR_TB_WR_UPPER);
  end

  // ==========================================================
  // Flag calculator
  // ==========================================================
  usr_flag_if flagBus ();  // Operands and calculated flags

  // Drive the calculator from the operation port
  always_comb begin
    flagBus.opKind    = opKind;
    flagBus.extended  = opExtended;
    flagBus.carryFlag = flagsReg[usr_pkg::XF_CARRY];
    flagBus.opA       = opA;
    flagBus.opB       = opB;
    flagBus.shiftAmt  = opShift;
  end

  // Result, carry and overflow of the whole operation
  usr_flag_calc flagCalc (
    .flags (flagBus.calc)
  );

  // ==========================================================
  // Flags register
  // ==========================================================

  // Which flags an operation changes
  always_comb begin
    opFlagUpdate = opValid && (opKind != usr_pkg::OP_COMPARE) &&
                   (opKind != usr_pkg::OP_OTHER);
    // Only add and subtract forms can overflow, and only when enabled
    ovUpdate     = opFlagUpdate && opOverflowEnable &&
                   (opKind != usr_pkg::OP_SHIFT_ALG);
    ovSet        = ovUpdate && flagBus.overflowOut;
  end

  // Next flags value, software write first, operation on top
  always_comb begin
    next_flags = flagsReg;
    if (wrFlags) begin
      next_flags = sprWdata & usr_pkg::FLAGS_WRITE_MASK;
    end
    if (opFlagUpdate && flagBus.carryUpdate) begin
      next_flags[usr_pkg::XF_CARRY] = flagBus.carryOut;
    end
    if (ovUpdate) begin
      next_flags[usr_pkg::XF_OVERFLOW] = flagBus.overflowOut;
    end
    if (ovSet) begin
      next_flags[usr_pkg::XF_SUMMARY] = 1'b1;
    end
  end

  // Flags register update
  always_ff @(posedge clk) begin
    if (srst) begin
      flagsReg <= usr_pkg::FLAGS_RESET;
    end else begin
      flagsReg <= next_flags;
    end
  end

  // Operation result register
  always_ff @(posedge clk) begin
    if (srst) begin
      opResult <= usr_pkg::RDATA_RESET;
      opDone   <= 1'b0;
    end else begin
      opDone <= opValid;
      if (opValid) begin
        opResult <= flagBus.result;
      end
    end
  end

  // ==========================================================
  // Link and loop count
  // ==========================================================

  // Link register, untouched by reset
  always_ff @(posedge clk) begin
    if (wrLink) begin
      linkAddr <= sprWdata;
    end else if (brValid && brLink) begin
      linkAddr <= brNextAddr;
    end
  end

  // Loop count register, untouched by reset
  always_ff @(posedge clk) begin
    if (wrCount) begin
      loopCount <= sprWdata;
    end else if (brValid && brDecCount) begin
      loopCount <= loopCount - 32'h00000001;
    end
  end

  // ==========================================================
  // Time base
  // ==========================================================

  // Counter, untouched by reset
  always_ff @(posedge clk) begin
    if (wrTbLower || wrTbUpper) begin
      if (wrTbLower) begin
        timeBase[31:0] <= sprWdata;
      end
      if (wrTbUpper) begin
        timeBase[63:32] <= sprWdata;
      end
    end else if (tbTick) begin
      timeBase <= timeBase + 64'h0000000000000001;
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================

  // Read data and refusal decode
  always_comb begin
    next_rdata   = usr_pkg::RDATA_RESET;
    next_refused = 1'b0;
    if (sprRead) begin
      unique case (sprNum)
        usr_pkg::SPR_FLAGS: begin
          next_rdata = flagsReg;
        end
        usr_pkg::SPR_LINK: begin
          next_rdata = linkAddr;
        end
        usr_pkg::SPR_COUNT: begin
          next_rdata = loopCount;
        end
        usr_pkg::SPR_TB_RD_LOWER: begin
          next_rdata = timeBase[31:0];
        end
        usr_pkg::SPR_TB_RD_UPPER: begin
          next_rdata = timeBase[63:32];
        end
        default: begin
          // Unknown number reads zero and is refused
          next_refused = 1'b1;
        end
      endcase
    end
    if (sprWrite) begin
      // User write at a time base number, or any unknown number
      if (sprHit(sprNum, usr_pkg::SPR_TB_WR_LOWER) ||
          sprHit(sprNum, usr_pkg::SPR_TB_WR_UPPER)) begin
        next_refused = !supervisor;
      end else if (!(wrFlags || wrLink || wrCount)) begin
        next_refused = 1'b1;
      end
    end
  end

  // Read data register, one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      sprRdata   <= usr_pkg::RDATA_RESET;
      sprRdValid <= 1'b0;
      sprRefused <= 1'b0;
    end else begin
      sprRdValid <= sprRead;
      sprRefused <= next_refused;
      if (sprRead) begin
        sprRdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Direct outputs
  // ==========================================================

  // Branch targets and flag fields
  always_comb begin
    linkTarget      = alignTarget(linkAddr);
    countTarget     = alignTarget(loopCount);
    loopCountNow    = loopCount;
    summaryOverflow = flagsReg[usr_pkg::XF_SUMMARY];
    overflowFlag    = flagsReg[usr_pkg::XF_OVERFLOW];
    carryFlag       = flagsReg[usr_pkg::XF_CARRY];
    stringBytes     = flagsReg[usr_pkg::XF_BYTES_HI:usr_pkg::XF_BYTES_LO];
  end

endmodule // usr_special_regs

// ### usr_special_regs_sva.sv
// Concurrent checks on the user special register block ports
`timescale 1ns/1ps
module usr_special_regs_chk (
  // Clock and reset
  input wire logic             clk,
  input wire logic             srst,
  // Register access port
  input wire logic [9:0]       sprNum,
  input wire logic             sprRead,
  input wire logic             sprWrite,
  input wire logic [31:0]      sprWdata,
  input wire logic             supervisor,
  input wire logic [31:0]      sprRdata,
  input wire logic             sprRdValid,
  input wire logic             sprRefused,
  // Operation and branch ports
  input wire logic             opValid,
  input wire usr_pkg::usr_op_t opKind,
  input wire logic             brValid,
  input wire logic             brLink,
  input wire logic             brDecCount,
  input wire logic [31:0]      brNextAddr,
  input wire logic [31:0]      linkTarget,
  input wire logic [31:0]      countTarget,
  input wire logic [31:0]      loopCountNow,
  // Flag fields
  input wire logic             summaryOverflow,
  input wire logic             overflowFlag,
  input wire logic             carryFlag,
  input wire logic [6:0]       stringBytes
);
  // ==========================================================
  // Single clock domain, reset disables every check
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_count_read: assert property (
    sprRead && sprNum == usr_pkg::SPR_COUNT
    |=> sprRdValid && sprRdata == $past(loopCountNow))
    else $error("loop count read data wrong");
  a_link_save: assert property (
    brValid && brLink && !sprWrite
    |=> linkTarget == ($past(brNextAddr) & usr_pkg::TARGET_MASK))
    else $error("link not saved from branch");
  a_count_wrap: assert property (
    brValid && brDecCount && !sprWrite
    |=> loopCountNow == $past(loopCountNow) - 32'h1)
    else $error("loop count decrement wrong");
  a_count_target: assert property (
    brValid && brDecCount && !sprWrite
    |=> countTarget == (($past(loopCountNow) - 32'h1)
                        & usr_pkg::TARGET_MASK))
    else $error("count target not aligned copy");
  a_tb_userwr: assert property (
    sprWrite && !supervisor
    && sprNum[9:1] == usr_pkg::SPR_TB_WR_LOWER[9:1] |=> sprRefused)
    else $error("user time base write taken");
  a_tb_read: assert property (
    sprRead && sprNum[9:1] == usr_pkg::SPR_TB_RD_LOWER[9:1]
    |=> sprRdValid && !sprRefused)
    else $error("time base read refused");
  a_flags_keep: assert property (
    opValid && !sprWrite && (opKind == usr_pkg::OP_COMPARE
    || opKind == usr_pkg::OP_OTHER)
    |=> $stable({summaryOverflow, overflowFlag, carryFlag}))
    else $error("compare changed a flag");
  a_so_sticky: assert property (
    summaryOverflow && !sprWrite |=> summaryOverflow)
    else $error("summary overflow dropped");
  a_ov_sets_so: assert property (
    $rose(overflowFlag) && !$past(sprWrite) |-> summaryOverflow)
    else $error("overflow without summary");
  a_bytes_write: assert property (
    sprWrite && sprNum == usr_pkg::SPR_FLAGS
    |=> stringBytes == $past(sprWdata[6:0]))
    else $error("byte count not written");
endmodule // usr_special_regs_chk

bind usr_special_regs usr_special_regs_chk chk (.clk, .srst, .sprNum,
  .sprRead, .sprWrite, .sprWdata, .supervisor, .sprRdata, .sprRdValid,
  .sprRefused, .opValid, .opKind, .brValid, .brLink, .brDecCount,
  .brNextAddr, .linkTarget, .countTarget, .loopCountNow,
  .summaryOverflow, .overflowFlag, .carryFlag, .stringBytes);

// ### usr_exec_model.sv
// Execution and branch unit model that completes operations
`timescale 1ns/1ps
module usr_exec_model (
  // Clock
  input  wire logic       clk,
  // Operation completion
  output usr_pkg::usr_op_t opKind,
  output logic            opValid,
  output logic            opExtended,
  output logic            opOverflowEnable,
  output logic [31:0]     opA,
  output logic [31:0]     opB,
  output logic [5:0]      opShift,
  // Branch completion and tick
  output logic            brValid,
  output logic            brLink,
  output logic            brDecCount,
  output logic [31:0]     brNextAddr,
  output logic            tbTick
);
  // Idle values at time zero
  initial begin
    {opValid, opExtended, opOverflowEnable, brValid, tbTick} = 5'h00;
    {brLink, brDecCount} = 2'h0;
    {opA, opB, brNextAddr} = 96'h0;
    opShift = 6'h00;
    opKind = usr_pkg::OP_OTHER;
  end

  // One operation completes for one cycle
  task automatic do_op(input usr_pkg::usr_op_t k, input logic e, oe,
                       input logic [31:0] a, b, input logic [5:0] s);
    @(negedge clk);
    opKind = k; opExtended = e; opOverflowEnable = oe;
    opA = a; opB = b; opShift = s; opValid = 1'h1;
    @(negedge clk);
    opValid = 1'h0;
  endtask

  // One branch completes for one cycle
  task automatic do_br(input logic l, d, input logic [31:0] n);
    @(negedge clk);
    brLink = l; brDecCount = d; brNextAddr = n; brValid = 1'h1;
    @(negedge clk);
    brValid = 1'h0;
  endtask

  // One time base tick
  task automatic tick();
    @(negedge clk);
    tbTick = 1'h1;
    @(negedge clk);
    tbTick = 1'h0;
  endtask
endmodule // usr_exec_model

// ### tb_usr_special_regs.sv
// Self-checking testbench for the user special register block
`timescale 1ns/1ps
module tb_usr_special_regs;
  typedef struct {
    usr_pkg::usr_op_t k;
    logic e, oe;
    logic [31:0] a, b;
    logic [5:0] s;
    logic [31:0] r;
    logic c, ca, ov;
  } usr_row_t;

  // Design connections
  logic clk = 1'h0, srst = 1'h1, sprRead = 1'h0, sprWrite = 1'h0;
  logic supervisor = 1'h0, sprRdValid, sprRefused, opValid, opExtended;
  logic [9:0] sprNum = 10'h000;
  logic [31:0] sprWdata = 32'h0, sprRdata, opA, opB, opResult, brNextAddr;
  logic [31:0] linkTarget, countTarget, loopCountNow;
  logic [5:0] opShift;
  logic [6:0] stringBytes;
  logic opOverflowEnable, opDone, brValid, brLink, brDecCount, tbTick;
  logic summaryOverflow, overflowFlag, carryFlag;
  usr_pkg::usr_op_t opKind;
  int error_cnt = 0, cmp_count = 0, cycles = 0;

  // Operation rows: kind ext oe a b shift result check ca ov
  usr_row_t rows[12] = '{
    '{usr_pkg::OP_ADD, 0, 1, 32'h7FFFFFFF, 1, 0, 32'h80000000, 1, 0, 1},
    '{usr_pkg::OP_ADD_CARRY, 0, 0, 32'hFFFFFFFF, 1, 0, 32'h0, 1, 1, 1},
    '{usr_pkg::OP_ADD_CARRY, 1, 1, 32'h0, 32'h0, 0, 32'h1, 1, 0, 0},
    '{usr_pkg::OP_SHIFT_ALG, 0, 0, 32'hFFFFFFF1, 0, 4, 32'hFFFFFFFF, 1, 1, 0},
    '{usr_pkg::OP_SHIFT_ALG, 0, 0, 32'h80000000, 0, 31, 32'hFFFFFFFF, 1, 0, 0},
    '{usr_pkg::OP_SHIFT_ALG, 0, 0, 32'h80000000, 0, 32, 32'hFFFFFFFF, 1, 1, 0},
    '{usr_pkg::OP_SHIFT_ALG, 0, 0, 32'h7FFFFFFF, 0, 4, 32'h07FFFFFF, 1, 0, 0},
    '{usr_pkg::OP_SUBF_CARRY, 0, 1, 32'h1, 32'h1, 0, 32'h0, 1, 1, 0},
    '{usr_pkg::OP_SUBF, 0, 1, 32'h1, 32'h80000000, 0, 32'h7FFFFFFF, 1, 1, 1},
    '{usr_pkg::OP_COMPARE, 0, 1, 32'h0, 32'h0, 0, 32'h0, 0, 1, 1},
    '{usr_pkg::OP_OTHER, 0, 1, 32'h5, 32'h3, 0, 32'h0, 0, 1, 1},
    '{usr_pkg::OP_ADD, 0, 1, 32'h1, 32'h1, 0, 32'h2, 1, 1, 0}};

  usr_special_regs dut (.clk, .srst, .sprNum, .sprRead, .sprWrite,
    .sprWdata, .supervisor, .sprRdata, .sprRdValid, .sprRefused, .opValid,
    .opKind, .opExtended, .opOverflowEnable, .opA, .opB, .opShift,
    .opResult, .opDone, .brValid, .brLink, .brDecCount, .brNextAddr,
    .linkTarget, .countTarget, .loopCountNow, .tbTick, .summaryOverflow,
    .overflowFlag, .carryFlag, .stringBytes);
  usr_exec_model exec (.clk, .opKind, .opValid, .opExtended,
    .opOverflowEnable, .opA, .opB, .opShift, .brValid, .brLink,
    .brDecCount, .brNextAddr, .tbTick);

  // ==========================================================
  // Clock, hang limit and shared tasks
  // ==========================================================
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 2000) begin
      error_cnt++;
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One register access held for one rising edge
  task automatic special_register_number(input logic w, input logic [9:0] n,
                     input logic [31:0] d, input logic s);
    @(negedge clk);
    sprWrite = w; sprRead = !w; sprNum = n; sprWdata = d; supervisor = s;
    @(negedge clk);
    sprWrite = 1'h0;
    sprRead = 1'h0;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'h0;
    chk("flags", 32'h0, {summaryOverflow, overflowFlag, carryFlag});
    chk("rdata", 32'h0, sprRdata);
    // Table of operations
    foreach (rows[i]) begin
      exec.do_op(rows[i].k, rows[i].e, rows[i].oe, rows[i].a, rows[i].b,
                 rows[i].s);
      if (rows[i].c) chk("result", rows[i].r, opResult);
      chk("done", 32'h1, opDone);
      chk("carry", rows[i].ca, carryFlag);
      chk("overflow", rows[i].ov, overflowFlag);
      chk("summary", 32'h1, summaryOverflow);
    end
    // Flag register stored and reserved bits
    special_register_number(1, usr_pkg::SPR_FLAGS, 32'hFFFFFFFF, 0);
    special_register_number(0, usr_pkg::SPR_FLAGS, 0, 0);
    chk("flags rd", 32'hE000FF7F, sprRdata);
    chk("rd valid", 32'h1, sprRdValid);
    chk("bytes", 32'h7F, stringBytes);
    special_register_number(1, usr_pkg::SPR_FLAGS, 0, 0);
    chk("summary clr", 32'h0, summaryOverflow);
    // Link saved by branch, low bits kept but not used
    exec.do_br(1, 0, 32'h00001003);
    chk("link tgt", 32'h00001000, linkTarget);
    special_register_number(0, usr_pkg::SPR_LINK, 0, 0);
    chk("link rd", 32'h00001003, sprRdata);
    special_register_number(1, usr_pkg::SPR_LINK, 32'hABCD0007, 0);
    chk("link wr", 32'hABCD0004, linkTarget);
    // Loop count wrap from zero
    special_register_number(1, usr_pkg::SPR_COUNT, 0, 0);
    exec.do_br(0, 1, 0);
    chk("count", 32'hFFFFFFFF, loopCountNow);
    chk("count tgt", 32'hFFFFFFFC, countTarget);
    special_register_number(0, usr_pkg::SPR_COUNT, 0, 0);
    chk("count rd", 32'hFFFFFFFF, sprRdata);
    // Time base load, tick with carry into upper half, two reads
    special_register_number(1, usr_pkg::SPR_TB_WR_LOWER, 32'hFFFFFFFF, 1);
    special_register_number(1, usr_pkg::SPR_TB_WR_UPPER, 32'h1, 1);
    exec.tick();
    special_register_number(0, usr_pkg::SPR_TB_RD_LOWER, 0, 0);
    chk("tb low", 32'h0, sprRdata);
    special_register_number(0, usr_pkg::SPR_TB_RD_UPPER, 0, 0);
    chk("tb high", 32'h2, sprRdata);
    // User write to time base and unknown number are refused
    special_register_number(1, usr_pkg::SPR_TB_WR_LOWER, 32'h5, 0);
    chk("refused", 32'h1, sprRefused);
    special_register_number(0, usr_pkg::SPR_TB_RD_LOWER, 0, 0);
    chk("tb kept", 32'h0, sprRdata);
    special_register_number(0, 10'h3FF, 0, 0);
    chk("unknown", 32'h1, sprRefused);
    chk("unknown rd", 32'h0, sprRdata);
    // Second reset keeps link and count
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    chk("count kept", 32'hFFFFFFFF, loopCountNow);
    chk("link kept", 32'hABCD0004, linkTarget);
    conclude();
  end
endmodule // tb_usr_special_regs
